// ===== core/uart_status_pkg.sv
package uart_status_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_CSA = 3'h1;
  localparam logic [2:0] ADDR_CSB = 3'h2;
  localparam logic [2:0] ADDR_CSC = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
  // ctrl_status_first bit positions
  localparam int CSA_RXC = 7;
  localparam int CSA_TXC = 6;
  localparam int CSA_TXE = 5;
  localparam int CSA_FE = 4;
  localparam int CSA_DOR = 3;
  localparam int CSA_PE = 2;
  // ctrl_status_second bit positions
  localparam int CSB_RXIE = 7;
  localparam int CSB_TXCIE = 6;
  localparam int CSB_TXEIE = 5;
  localparam int CSB_RXEN = 4;
  localparam int CSB_TRANSMITTER_ENABLE_BIT = 3;
  localparam int CSB_RX9 = 1;
  localparam int CSB_TX9 = 0;
  // ctrl_status_third bit positions, char size in bits 2:0
  localparam int CSC_SYNC = 6;
  localparam int CSC_PAREN = 5;
  localparam int CSC_PARODD = 4;
  localparam int CSC_STOP2 = 3;
  localparam logic [2:0] CHAR_SIZE_9 = 3'h7;
  localparam logic [2:0] CHAR_SIZE_RESET = 3'h3;
  localparam int BAUD_W = 12;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h067;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b011,
    ST_PARITY = 3'b010,
    ST_STOP = 3'b110
  } frame_st_t;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic pe;
  } rx_entry_t;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic rx_ie;
    logic txc_ie;
    logic txe_ie;
    logic tx_ninth;
  } ctrl_t;

  typedef struct packed {
    logic sync_mode;
    logic par_en;
    logic par_odd;
    logic stop2;
    logic [2:0] char_size;
  } fmt_t;

  typedef struct packed {
    logic [7:0] rdata;
    ctrl_t ctrl;
    fmt_t fmt;
    logic [BAUD_W-1:0] baud;
    logic [8:0] tx_buf;
    logic tx_full;
    frame_st_t tx_st;
    logic [8:0] tx_shift;
    logic [3:0] tx_idx;
    logic [BAUD_W-1:0] tx_cnt;
    logic tx_par;
    logic tx_done;
    logic tx_drive;
    logic tx_line;
    frame_st_t rx_st;
    logic [8:0] rx_shift;
    logic [3:0] rx_idx;
    logic [BAUD_W-1:0] rx_cnt;
    logic rx_par_bit;
    logic rx_par_en;
    rx_entry_t rx_wait_entry;
    logic rx_wait;
    logic dor;
    rx_entry_t [1:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    logic sclk_prev;
  } state_t;
endpackage

// ===== core/uart_status.sv
// Behaviour
// - tx buffer empty flag high while buffer empty, low while holding unsent data
// - buffer-empty irq requested while its enable, flag and global enable all hold
// - writing the data register clears the tx buffer empty flag
// - tx complete set after frame shifted out with no data waiting
// - tx complete cleared when its interrupt is taken or on write-one
// - tx complete irq requested while flag set, enable and global enable
// - with parity enabled, parity bit goes between last data and first stop
// - disabled transmitter finishes shift register and buffer before releasing pin
// - receiver enable takes the input pin; sync mode clocks on sync clock pin
// - receive from valid start bit to first stop bit; second stop ignored
// - at first stop bit the frame moves into the receive buffer
// - unused upper data bits read as zero for short characters
// - ninth bit, framing and parity error flags buffered per frame; data read advances fifo
// - rx complete flag high while buffer holds unread data
// - clearing receiver enable aborts frame, flushes buffer, clears flag, frees pin
// - rx complete irq requested while flag, enable and global enable hold
// - error flags never raise an interrupt
// - writes to error and buffer-empty flag positions are ignored
// - framing error reflects the first stop bit only
// - overrun on start bit with full buffer and waiting char; cleared on move
// - parity checker on with upper mode bit, odd/even from lower bit
// - parity error only reported if checking was on when received
// - parity is xor of data bits, inverted for odd
// - shift register loads when idle or right after last stop bit
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module uart_status
  import uart_status_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial_in_i,
  input wire logic sync_clock_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic serial_in_own_o,
  input wire logic global_irq_enable_i,
  input wire logic tx_complete_irq_ack_i,
  output logic tx_empty_irq_o,
  output logic tx_complete_irq_o,
  output logic rx_complete_irq_o
);

  function automatic logic [3:0] data_bits(input logic [2:0] cs);
    if (cs == CHAR_SIZE_9)
      data_bits = 4'h9;
    else if (cs[2])
      data_bits = 4'h8;
    else
      data_bits = {2'b01, cs[1:0]} + 4'h1;
  endfunction

  function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [3:0] nb);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++)
    begin
      if (i < int'(nb))
        m[i] = d[i];
    end
    mask_data = m;
  endfunction

  function automatic logic calc_parity(input logic [8:0] d, input logic [3:0] nb, input logic odd);
    calc_parity = (^mask_data(d, nb)) ^ odd;
  endfunction

  state_t state_ff;
  state_t nxt_state;
  logic sclk_rise;
  logic tx_step;
  logic rx_step;
  logic [3:0] nb;
  logic pop;
  logic space;
  logic frame_done;
  logic push;
  rx_entry_t new_entry;
  rx_entry_t push_entry;
  rx_entry_t head;
  logic rx_complete_flag;
  logic tx_buffer_empty_flag;

  always_comb
  begin
    nxt_state = state_ff;
    sclk_rise = state_ff.fmt.sync_mode & sync_clock_i & ~state_ff.sclk_prev;
    tx_step = state_ff.fmt.sync_mode ? sclk_rise : (state_ff.tx_cnt == '0);
    rx_step = state_ff.fmt.sync_mode ? sclk_rise : (state_ff.rx_cnt == '0);
    nb = data_bits(state_ff.fmt.char_size);
    head = state_ff.fifo[state_ff.rd_ptr];
    rx_complete_flag = (state_ff.count != 2'h0);
    tx_buffer_empty_flag = ~state_ff.tx_full;
    pop = rd_i & (addr_i == ADDR_DATA) & rx_complete_flag;
    space = (state_ff.count != 2'h2) | pop;
    frame_done = 1'b0;
    push = 1'b0;
    push_entry = state_ff.rx_wait_entry;
    new_entry = '0;
    nxt_state.sclk_prev = sync_clock_i;
    nxt_state.rdata = 8'h00;

    // register port
    if (rd_i)
    begin
      case (addr_i)
        ADDR_DATA: nxt_state.rdata = head.data[7:0];
        ADDR_CSA:
        begin
          nxt_state.rdata[CSA_RXC] = rx_complete_flag;
          nxt_state.rdata[CSA_TXC] = state_ff.tx_done;
          nxt_state.rdata[CSA_TXE] = tx_buffer_empty_flag;
          nxt_state.rdata[CSA_FE] = head.fe & rx_complete_flag;
          nxt_state.rdata[CSA_DOR] = state_ff.dor;
          nxt_state.rdata[CSA_PE] = head.pe & rx_complete_flag;
        end
        ADDR_CSB:
        begin
          nxt_state.rdata[CSB_RXIE] = state_ff.ctrl.rx_ie;
          nxt_state.rdata[CSB_TXCIE] = state_ff.ctrl.txc_ie;
          nxt_state.rdata[CSB_TXEIE] = state_ff.ctrl.txe_ie;
          nxt_state.rdata[CSB_RXEN] = state_ff.ctrl.rx_en;
          nxt_state.rdata[CSB_TRANSMITTER_ENABLE_BIT] = state_ff.ctrl.tx_en;
          nxt_state.rdata[CSB_RX9] = head.data[8] & rx_complete_flag;
          nxt_state.rdata[CSB_TX9] = state_ff.ctrl.tx_ninth;
        end
        ADDR_CSC: nxt_state.rdata = {1'b0, state_ff.fmt};
        ADDR_BAUD_LO: nxt_state.rdata = state_ff.baud[7:0];
        ADDR_BAUD_HI: nxt_state.rdata = {4'h0, state_ff.baud[BAUD_W-1:8]};
        default: nxt_state.rdata = 8'h00;
      endcase
    end
    if (wr_i)
    begin
      case (addr_i)
        ADDR_DATA:
        begin
          nxt_state.tx_buf = {state_ff.ctrl.tx_ninth, wdata_i};
          nxt_state.tx_full = 1'b1;
        end
        ADDR_CSB:
        begin
          nxt_state.ctrl.rx_ie = wdata_i[CSB_RXIE];
          nxt_state.ctrl.txc_ie = wdata_i[CSB_TXCIE];
          nxt_state.ctrl.txe_ie = wdata_i[CSB_TXEIE];
          nxt_state.ctrl.rx_en = wdata_i[CSB_RXEN];
          nxt_state.ctrl.tx_en = wdata_i[CSB_TRANSMITTER_ENABLE_BIT];
          nxt_state.ctrl.tx_ninth = wdata_i[CSB_TX9];
        end
        ADDR_CSC: nxt_state.fmt = wdata_i[6:0];
        ADDR_BAUD_LO: nxt_state.baud[7:0] = wdata_i;
        ADDR_BAUD_HI: nxt_state.baud[BAUD_W-1:8] = wdata_i[3:0];
        default: nxt_state.rdata = nxt_state.rdata;
      endcase
    end
    // only the tx complete bit of ctrl_status_first is writable
    if ((wr_i & (addr_i == ADDR_CSA) & wdata_i[CSA_TXC]) | tx_complete_irq_ack_i)
      nxt_state.tx_done = 1'b0;

    // transmitter
    if (state_ff.tx_st != ST_IDLE)
      nxt_state.tx_cnt = (state_ff.tx_cnt == '0) ? state_ff.baud : state_ff.tx_cnt - 1'b1;
    case (state_ff.tx_st)
      ST_IDLE:
      begin
        if (state_ff.tx_full & (state_ff.ctrl.tx_en | state_ff.tx_drive))
        begin
          nxt_state.tx_st = ST_START;
          nxt_state.tx_cnt = state_ff.baud;
        end
      end
      ST_START:
        if (tx_step)
        begin
          nxt_state.tx_st = ST_DATA;
          nxt_state.tx_idx = 4'h0;
        end
      ST_DATA:
        if (tx_step)
        begin
          if (state_ff.tx_idx == nb - 4'h1)
          begin
            nxt_state.tx_st = state_ff.fmt.par_en ? ST_PARITY : ST_STOP;
            nxt_state.tx_idx = 4'h0;
          end
          else
          begin
            nxt_state.tx_shift = {1'b0, state_ff.tx_shift[8:1]};
            nxt_state.tx_idx = state_ff.tx_idx + 4'h1;
          end
        end
      ST_PARITY:
        if (tx_step)
          nxt_state.tx_st = ST_STOP;
      ST_STOP:
        if (tx_step)
        begin
          if (state_ff.fmt.stop2 & (state_ff.tx_idx == 4'h0))
            nxt_state.tx_idx = 4'h1;
          else if (state_ff.tx_full)
            nxt_state.tx_st = ST_START;
          else
          begin
            nxt_state.tx_st = ST_IDLE;
            nxt_state.tx_done = 1'b1;
          end
        end
      default: nxt_state.tx_st = ST_IDLE;
    endcase
    if (nxt_state.tx_st == ST_START && state_ff.tx_st != ST_START)
    begin
      nxt_state.tx_shift = state_ff.tx_buf;
      nxt_state.tx_par = calc_parity(state_ff.tx_buf, nb, state_ff.fmt.par_odd);
      nxt_state.tx_full = wr_i & (addr_i == ADDR_DATA);
      nxt_state.tx_cnt = state_ff.baud;
    end
    // pin stays overridden until both shift register and buffer drain
    nxt_state.tx_drive = state_ff.ctrl.tx_en |
      (state_ff.tx_drive & ((state_ff.tx_st != ST_IDLE) | state_ff.tx_full));
    case (nxt_state.tx_st)
      ST_START: nxt_state.tx_line = 1'b0;
      ST_DATA: nxt_state.tx_line = nxt_state.tx_shift[0];
      ST_PARITY: nxt_state.tx_line = nxt_state.tx_par;
      default: nxt_state.tx_line = 1'b1;
    endcase

    // receiver
    if (state_ff.rx_st != ST_IDLE)
      nxt_state.rx_cnt = (state_ff.rx_cnt == '0) ? state_ff.baud : state_ff.rx_cnt - 1'b1;
    case (state_ff.rx_st)
      ST_IDLE:
        if (state_ff.ctrl.rx_en & ~serial_in_i & (~state_ff.fmt.sync_mode | sclk_rise))
        begin
          // sync mode has no half-bit check, so its start is already valid here
          if (state_ff.fmt.sync_mode & (state_ff.count == 2'h2) & state_ff.rx_wait & ~pop)
            nxt_state.dor = 1'b1;
          nxt_state.rx_par_en = state_ff.fmt.par_en;
          nxt_state.rx_idx = 4'h0;
          nxt_state.rx_shift = 9'h000;
          nxt_state.rx_st = state_ff.fmt.sync_mode ? ST_DATA : ST_START;
          nxt_state.rx_cnt = {1'b0, state_ff.baud[BAUD_W-1:1]};
        end
      ST_START:
        if (rx_step)
        begin
          nxt_state.rx_st = serial_in_i ? ST_IDLE : ST_DATA;
          // overrun only on a confirmed start, not on a low stop bit or a glitch
          if (~serial_in_i & (state_ff.count == 2'h2) & state_ff.rx_wait & ~pop)
            nxt_state.dor = 1'b1;
        end
      ST_DATA:
        if (rx_step)
        begin
          nxt_state.rx_shift[state_ff.rx_idx] = serial_in_i;
          if (state_ff.rx_idx == nb - 4'h1)
            nxt_state.rx_st = state_ff.rx_par_en ? ST_PARITY : ST_STOP;
          else
            nxt_state.rx_idx = state_ff.rx_idx + 4'h1;
        end
      ST_PARITY:
        if (rx_step)
        begin
          nxt_state.rx_par_bit = serial_in_i;
          nxt_state.rx_st = ST_STOP;
        end
      ST_STOP:
        if (rx_step)
        begin
          // back to idle at once: a second stop bit is never looked at
          nxt_state.rx_st = ST_IDLE;
          frame_done = 1'b1;
        end
      default: nxt_state.rx_st = ST_IDLE;
    endcase
    new_entry.data = mask_data(state_ff.rx_shift, nb);
    new_entry.fe = ~serial_in_i;
    new_entry.pe = state_ff.rx_par_en &
      (calc_parity(state_ff.rx_shift, nb, state_ff.fmt.par_odd) != state_ff.rx_par_bit);
    if (frame_done)
    begin
      if (state_ff.rx_wait)
      begin
        if (space)
        begin
          push = 1'b1;
          nxt_state.rx_wait_entry = new_entry;
        end
      end
      else if (space)
      begin
        push = 1'b1;
        push_entry = new_entry;
      end
      else
      begin
        nxt_state.rx_wait = 1'b1;
        nxt_state.rx_wait_entry = new_entry;
      end
    end
    else if (state_ff.rx_wait & space)
    begin
      push = 1'b1;
      nxt_state.rx_wait = 1'b0;
    end
    if (push)
    begin
      nxt_state.fifo[state_ff.rd_ptr ^ state_ff.count[0]] = push_entry;
      if (nxt_state.dor == state_ff.dor)
        nxt_state.dor = 1'b0;
    end
    if (pop)
      nxt_state.rd_ptr = ~state_ff.rd_ptr;
    nxt_state.count = state_ff.count - {1'b0, pop} + {1'b0, push};
    if (~state_ff.ctrl.rx_en)
    begin
      nxt_state.rx_st = ST_IDLE;
      nxt_state.count = 2'h0;
      nxt_state.rx_wait = 1'b0;
      nxt_state.dor = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= '0;
      state_ff.fmt.char_size <= CHAR_SIZE_RESET;
      state_ff.baud <= BAUD_RESET;
      state_ff.tx_line <= 1'b1;
    end
    else
      state_ff <= nxt_state;
  end

  assign rdata_o = state_ff.rdata;
  assign serial_out_o = state_ff.tx_line;
  assign serial_out_oe_o = state_ff.tx_drive;
  assign serial_in_own_o = state_ff.ctrl.rx_en;
  assign tx_empty_irq_o = state_ff.ctrl.txe_ie & tx_buffer_empty_flag & global_irq_enable_i;
  assign tx_complete_irq_o = state_ff.ctrl.txc_ie & state_ff.tx_done & global_irq_enable_i;
  // error flags deliberately feed no request line
  assign rx_complete_irq_o = state_ff.ctrl.rx_ie & rx_complete_flag & global_irq_enable_i;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  a_data_write_fills: assert property ((wr_i && addr_i == ADDR_DATA) |=> !tx_buffer_empty_flag)
    else $error("data write did not clear buffer empty");
  a_empty_irq_req: assert property ((state_ff.ctrl.txe_ie && global_irq_enable_i && !state_ff.tx_full)
    |-> tx_empty_irq_o)
    else $error("buffer empty irq missing");
  a_tx_complete_set: assert property ((state_ff.tx_st == ST_STOP && tx_step && !state_ff.tx_full &&
    !(state_ff.fmt.stop2 && state_ff.tx_idx == 4'h0)) |=> state_ff.tx_done && state_ff.tx_st == ST_IDLE)
    else $error("tx complete not set after last stop");
  a_tx_complete_ack: assert property ((tx_complete_irq_ack_i && state_ff.tx_st == ST_IDLE)
    |=> !state_ff.tx_done)
    else $error("tx complete not cleared by ack");
  a_parity_slot: assert property ((state_ff.tx_st == ST_DATA && nxt_state.tx_st == ST_STOP)
    |-> !state_ff.fmt.par_en)
    else $error("parity bit skipped");
  a_parity_order: assert property ((state_ff.tx_st == ST_PARITY) |-> $past(state_ff.tx_st) inside {ST_DATA, ST_PARITY}
    && state_ff.fmt.par_en && serial_out_o == state_ff.tx_par)
    else $error("parity bit out of place");
  a_tx_hold_pin: assert property ((!state_ff.ctrl.tx_en && (state_ff.tx_st != ST_IDLE || state_ff.tx_full)
    && serial_out_oe_o) |=> serial_out_oe_o)
    else $error("pin released before transmitter drained");
  a_rx_flush: assert property ((wr_i && addr_i == ADDR_CSB && !wdata_i[CSB_RXEN]) |=> ##1
    (state_ff.count == 2'h0 && !rx_complete_flag && state_ff.rx_st == ST_IDLE && !serial_in_own_o))
    else $error("receiver disable did not flush");
  a_read_pops: assert property ((pop && !push && state_ff.count == 2'h1) |=> state_ff.count == 2'h0)
    else $error("data read did not advance fifo");
  a_short_mask: assert property ((rd_i && addr_i == ADDR_DATA && state_ff.fmt.char_size == 3'h0 && rx_complete_flag)
    |=> rdata_o[7:5] == 3'h0)
    else $error("unused upper bits not zero");

  c_tx_frame: cover property (state_ff.tx_st == ST_STOP ##1 state_ff.tx_done);
  c_rx_push: cover property (push ##1 rx_complete_flag);
  c_overrun: cover property (state_ff.dor);
  c_parity_err: cover property (push && push_entry.pe);

endmodule // uart_status

// ===== verification/uart_node_model.sv
`timescale 1ns/1ps
module uart_node_model #(
  parameter int BIT = 16
) (
  input wire logic clock_i,
  input wire logic line_i,
  input wire logic [3:0] nbits_i,
  input wire logic par_en_i,
  output logic line_o,
  output logic got_o,
  output logic [9:0] got_data_o
);
  logic [9:0] v;

  initial
  begin
    line_o = 1'b1;
  end

  task automatic bit_out(input logic b);
    line_o <= b;
    repeat (BIT) @(posedge clock_i);
  endtask

  // gap of two bit times after each frame; the line keeps the stop bit value through it
  task automatic send(input logic [8:0] d, input logic par, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < nbits_i; i++)
    begin
      bit_out(d[i]);
    end
    if (par_en_i)
    begin
      bit_out(par);
    end
    bit_out(stop);
    repeat (2 * BIT) @(posedge clock_i);
  endtask

  // samples mid-bit: data lsb first, parity, then stop in the top used bit
  always
  begin
    @(posedge clock_i);
    got_o <= 1'b0;
    if (line_i === 1'b0)
    begin
      v = 10'h000;
      repeat (BIT / 2) @(posedge clock_i);
      for (int i = 0; i <= nbits_i + par_en_i; i++)
      begin
        repeat (BIT) @(posedge clock_i);
        v[i] = line_i;
      end
      got_data_o <= v;
      got_o <= 1'b1;
    end
  end
endmodule // uart_node_model

// ===== verification/uart_status_test.sv
`timescale 1ns/1ps
module uart_status_test;
  import uart_status_pkg::*;
  localparam int BIT = 16;
  logic clock_i, reset_n_i, wr_i, rd_i, serial_in_i, sync_clock_i;
  logic global_irq_enable_i, tx_complete_irq_ack_i, serial_out_o, serial_out_oe_o, serial_in_own_o;
  logic tx_empty_irq_o, tx_complete_irq_o, rx_complete_irq_o, par_en, got, rd_pend, txline;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [3:0] nbits;
  logic [9:0] got_data;
  logic [9:0] exp_q[$];
  logic [9:0] tx_q[$];
  logic [8:0] d[4];
  int errors, n_tests, cycles, seed;

  // released transmit pin is pulled high
  assign txline = serial_out_oe_o ? serial_out_o : 1'b1;

  uart_status dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_in_i(serial_in_i), .sync_clock_i(sync_clock_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .serial_in_own_o(serial_in_own_o),
    .global_irq_enable_i(global_irq_enable_i), .tx_complete_irq_ack_i(tx_complete_irq_ack_i),
    .tx_empty_irq_o(tx_empty_irq_o), .tx_complete_irq_o(tx_complete_irq_o), .rx_complete_irq_o(rx_complete_irq_o));

  uart_node_model #(.BIT(BIT)) node (.clock_i(clock_i), .line_i(txline), .nbits_i(nbits), .par_en_i(par_en),
    .line_o(serial_in_i), .got_o(got), .got_data_o(got_data));

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic chk(input logic [9:0] val, input logic [9:0] exp);
    n_tests++;
    if (val !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, val, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // strobes go up right after a rising edge and drop right after the sampling edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back({2'b00, exp});
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask

  task automatic wait_txc;
    for (int k = 0; k < 3000 && tx_complete_irq_o !== 1'b1; k++)
    begin
      @(posedge clock_i);
    end
    chk(tx_complete_irq_o, 1'b1);
    repeat (2) @(negedge clock_i);
  endtask

  always @(posedge clock_i)
  begin
    if (rd_pend)
    begin
      chk({2'b00, rdata_o}, exp_q.pop_front());
    end
    if (got)
    begin
      chk(got_data, tx_q.pop_front());
    end
    rd_pend <= rd_i;
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    seed = 32'h553b1225;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    reset_n_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sync_clock_i = 1'b0;
    global_irq_enable_i = 1'b1;
    tx_complete_irq_ack_i = 1'b0;
    nbits = 4'h8;
    par_en = 1'b1;
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rd(ADDR_CSA, 8'h20);
    rd(ADDR_CSC, 8'h03);
    rd(3'h6, 8'h00);
    wr(ADDR_BAUD_LO, 8'h0F);
    wr(ADDR_BAUD_HI, 8'h00);
    wr(ADDR_CSB, 8'h78);
    @(negedge clock_i);
    chk(tx_empty_irq_o, 1'b1);
    chk(serial_in_own_o, 1'b1);
    @(posedge clock_i);
    global_irq_enable_i <= 1'b0;
    @(negedge clock_i);
    chk(tx_empty_irq_o, 1'b0);
    @(posedge clock_i);
    global_irq_enable_i <= 1'b1;
    // even parity with acknowledge, then odd parity with deferred disable
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CSC, m[0] ? 8'h33 : 8'h23);
      for (int j = 0; j < 2; j++)
      begin
        d[j] = 9'($random(seed)) & 9'h0FF;
        tx_q.push_back({1'b1, ^d[j][7:0] ^ m[0], d[j][7:0]});
        wr(ADDR_DATA, d[j][7:0]);
      end
      rd(ADDR_CSA, 8'h00);
      @(negedge clock_i);
      chk(tx_empty_irq_o, 1'b0);
      if (m == 1)
      begin
        wr(ADDR_CSB, 8'h70);
        @(negedge clock_i);
        chk(serial_out_oe_o, 1'b1);
      end
      wait_txc;
      chk(serial_out_oe_o, m[0] ? 1'b0 : 1'b1);
      rd(ADDR_CSA, 8'h60);
      chk(tx_complete_irq_o, 1'b1);
      if (m == 0)
      begin
        tx_complete_irq_ack_i <= 1'b1;
        @(posedge clock_i);
        tx_complete_irq_ack_i <= 1'b0;
        @(posedge clock_i);
      end
      else
      begin
        wr(ADDR_CSA, 8'hFF);
      end
      rd(ADDR_CSA, 8'h20);
    end
    // four frames unread: good, bad parity, bad stop, then one lost
    wr(ADDR_CSB, 8'hF0);
    wr(ADDR_CSC, 8'h23);
    for (int j = 0; j < 4; j++)
    begin
      d[j] = 9'($random(seed)) & 9'h0FF;
      node.send(d[j], ^d[j][7:0] ^ (j == 1), j != 2);
    end
    repeat (4) @(negedge clock_i);
    chk(rx_complete_irq_o, 1'b1);
    rd(ADDR_CSA, 8'hA8);
    rd(ADDR_DATA, d[0][7:0]);
    rd(ADDR_CSA, 8'hA4);
    rd(ADDR_DATA, d[1][7:0]);
    rd(ADDR_CSA, 8'hB0);
    rd(ADDR_DATA, d[2][7:0]);
    rd(ADDR_CSA, 8'h20);
    @(negedge clock_i);
    chk(rx_complete_irq_o, 1'b0);
    // five-bit characters with checking off
    wr(ADDR_CSC, 8'h00);
    nbits = 4'h5;
    par_en = 1'b0;
    d[0] = 9'($random(seed));
    node.send(d[0], 1'b1, 1'b1);
    rd(ADDR_CSA, 8'hA0);
    rd(ADDR_DATA, {3'b000, d[0][4:0]});
    // synchronous mode: the bench raises the sync clock pin in the middle of each bit
    wr(ADDR_CSC, 8'h43);
    nbits = 4'h8;
    d[1] = 9'($random(seed)) & 9'h0FF;
    fork
      node.send(d[1], 1'b0, 1'b1);
      for (int k = 0; k < 24; k++)
      begin
        repeat (BIT / 2) @(posedge clock_i);
        sync_clock_i <= ~sync_clock_i;
      end
    join
    rd(ADDR_CSA, 8'hA0);
    rd(ADDR_DATA, d[1][7:0]);
    wr(ADDR_CSC, 8'h07);
    nbits = 4'h9;
    d[0] = 9'($random(seed)) | 9'h100;
    node.send(d[0], 1'b0, 1'b1);
    rd(ADDR_CSB, 8'hF2);
    rd(ADDR_DATA, d[0][7:0]);
    // one frame buffered, then receiver disabled in mid-frame
    node.send(d[0], 1'b0, 1'b1);
    fork
      node.send(d[0], 1'b0, 1'b1);
      begin
        repeat (3 * BIT) @(posedge clock_i);
        wr(ADDR_CSB, 8'hE0);
      end
    join
    @(negedge clock_i);
    chk(serial_in_own_o, 1'b0);
    rd(ADDR_CSA, 8'h20);
    wr(ADDR_CSB, 8'hF0);
    rd(ADDR_CSA, 8'h20);
    repeat (2) @(posedge clock_i);
    chk(10'(tx_q.size()), 10'h000);
    end_of_test();
  end
endmodule // uart_status_test
